/* pkg/uart_status_control_regs.svh */
// Register offsets, field positions, reset values and timing counts
// of the serial status/control block. Included by the design files.
`ifndef UART_STATUS_CONTROL_REGS_SVH
`define UART_STATUS_CONTROL_REGS_SVH

// ==================================================================
// Byte offsets on the register bus
`define OFS_STATUS    8'h00
`define OFS_MODE      8'h04
`define OFS_BAUD      8'h08
`define OFS_TXDATA    8'h0C
`define OFS_RXDATA    8'h10
`define OFS_IRQ_STAT  8'h14
`define OFS_IRQ_MASK  8'h18

// ==================================================================
// Status/control field positions
`define STA_TXINV     14
`define STA_TXEN      10
`define STA_TXBF      9
`define STA_TX_SHIFTER_EMPTY      8
`define STA_RXSEL_LO  6
`define STA_ADDRESS_DETECT_ENABLE     5
`define STA_RECEIVER_IDLE     4
`define STA_PARITY_ERROR_FLAG      3
`define STA_FRAMING_ERROR_FLAG      2
`define STA_OVERRUN_ERROR_FLAG      1
`define STA_RXDA      0

// Mode register field positions
`define MODE_STOP     0
`define MODE_PSEL_LO  1
`define MODE_INFRARED_ENCODER_ENABLE     3

// ==================================================================
// Reset values
`define STA_RESET     16'h0110
`define BAUD_RESET    16'h0000

// ==================================================================
// Timing counts, in 16x oversample ticks or entries
`define SUB_LAST      4'd15
`define SUB_MID       4'd7
`define IR_PULSE      4'd3
`define FIFO_DEPTH    3'd4
`define RX_LVL_3Q     3'd3

`endif

/* pkg/uart_types_pkg.sv */
// Types shared by the serial status/control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package uart_types_pkg;

  // ================================================================
  // Receive buffer entry: error flags travel with their character
  typedef struct packed {
    logic       parity_error_flag;   // Parity failed
    logic       framing_error_flag;   // Stop bit was low
    logic [8:0] data;   // Up to nine data bits
  } rx_entry_t;

  // Transmitter and receiver sequence states
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage

`default_nettype wire

/* design/uart_fifo.sv */
// Four-entry shifting buffer; the head entry is always a register.
// Assumes a single clock and a synchronous active-low reset.
`include "uart_status_control_regs.svh"
`default_nettype none

module uart_fifo #(
  parameter int DW = 9
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          flush,      // Drops every entry
  input  wire logic          push,
  input  wire logic [DW-1:0] push_data,
  input  wire logic          pop,
  output logic      [DW-1:0] head,       // Oldest entry
  output logic      [2:0]    count
);
  logic [DW-1:0] ent [4];   // Entry 0 is the head
  logic          do_pop;
  logic          do_push;

  // A push into a full buffer is accepted only alongside a pop
  assign do_pop  = pop && (count != 3'd0);
  assign do_push = push && ((count != `FIFO_DEPTH) || do_pop);
  assign head    = ent[0];

  // ================================================================
  // One shifting stage per entry
  for (genvar i = 0; i < 4; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        ent[i] <= '0;
      end else if (do_pop) begin
        if (do_push && (3'(i) == count - 3'd1)) begin
          ent[i] <= push_data;
        end else if (i < 3) begin
          ent[i] <= ent[(i < 3) ? i + 1 : i];
        end
      end else if (do_push && (3'(i) == count)) begin
        ent[i] <= push_data;
      end
    end
  end

  // Fill level; flush wins over everything
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      count <= 3'd0;
    end else begin
      count <= count + 3'(do_push) - 3'(do_pop);
    end
  end

endmodule

`default_nettype wire

/* design/uart_status_control.sv */
// Serial transmitter/receiver with status/control flags on AXI4-Lite.
// Assumes one 40 MHz clock; the serial input is already synchronous.
//
// Behaviour
// - Buffer-full flag set when no room left
// - Receive interrupt level: each, three, four characters
// - Address detect keeps ninth-bit-set characters only, in nine-bit mode
// - Idle flag reads one unless receiving
// - Parity error flag follows head character
// - Framing error flag follows head character
// - Overrun set on completion into full buffer
// - Clearing overrun empties buffer, resets shifter
// - Data-available flag while buffer not empty
// - Polarity invert acts only with infrared encoder
// - Four data/parity encodings, nine-bit without parity
`include "uart_status_control_regs.svh"
`default_nettype none

module uart_status_control
  import uart_types_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        serial_rx_in,  // Receive line, idle high
  output logic             serial_tx_pin, // Transmit line
  output logic             serial_tx_oe,  // High while the block owns the pin
  output logic             irq            // Level interrupt
);
  // ================================================================
  // Control and status state
  logic        tx_enable;
  logic        tx_polarity_invert;
  logic        address_detect_enable;
  logic [1:0]  rx_irq_level_sel;
  logic [1:0]  data_parity_sel;        // 11 nine-bit, 10 odd, 01 even, 00 none
  logic        two_stop;
  logic        infrared_encoder_enable;
  logic        overrun_error_flag;
  logic [15:0] baud_div;               // 16x tick every baud_div+1 clocks
  logic [3:0]  irq_status;             // Rx level, tx empty, overrun, char error
  logic [3:0]  irq_mask;
  logic [3:0]  irq_event;

  // Bus slave holding registers
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        do_read;
  logic        wr_sta;

  // Datapath
  logic [15:0] baud_cnt;
  logic        tick16;                 // One-cycle 16x oversample enable
  logic        nine_bit;
  logic        parity_on;
  tx_state_t   tx_state;
  logic [3:0]  tx_sub;
  logic [3:0]  tx_bit;
  logic [8:0]  tx_shift;
  logic        tx_par;
  logic        tx_line;
  logic        next_tx_pin;
  logic [8:0]  tx_head;
  logic [2:0]  tx_count;
  logic        tx_push;
  logic        tx_load;
  logic        tx_buffer_full;
  logic        tx_shifter_empty;
  rx_state_t   rx_state;
  logic [3:0]  rx_sub;
  logic [3:0]  rx_bit;
  logic [8:0]  rx_shift;
  logic        rx_parity_error_flag_q;
  logic        rx_done;                // Stop bit sampled this cycle
  logic        rx_accept;
  logic        rx_push;
  logic        rx_pop;
  logic        ovr_clear;
  rx_entry_t   rx_new;
  rx_entry_t   rx_head;
  logic [2:0]  rx_count;
  logic        rx_data_available;
  logic        receiver_idle;
  logic        rx_level_hit;
  logic [15:0] sta_word;

  // ================================================================
  // AXI4-Lite write side: address and data taken in either order
  assign awready  = !aw_held;
  assign wready   = !w_held;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_sta   = do_write && (aw_addr_q == `OFS_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        // Offsets above OFS_IRQ_MASK answer with a slave error
        bresp   <= (aw_addr_q > `OFS_IRQ_MASK) ? 2'b10 : 2'b00;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ================================================================
  // Control fields; only the low two byte lanes carry them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_enable               <= 1'b0;
      tx_polarity_invert      <= 1'b0;
      address_detect_enable   <= 1'b0;
      rx_irq_level_sel        <= 2'b00;
      data_parity_sel         <= 2'b00;
      two_stop                <= 1'b0;
      infrared_encoder_enable <= 1'b0;
      baud_div                <= `BAUD_RESET;
      irq_mask                <= 4'h0;
    end else if (do_write) begin
      if (wr_sta && wstrb_q[1]) begin
        tx_polarity_invert <= wdata_q[`STA_TXINV];
        tx_enable          <= wdata_q[`STA_TXEN];
      end
      if (wr_sta && wstrb_q[0]) begin
        rx_irq_level_sel      <= wdata_q[`STA_RXSEL_LO +: 2];
        address_detect_enable <= wdata_q[`STA_ADDRESS_DETECT_ENABLE];
      end
      if (aw_addr_q == `OFS_MODE && wstrb_q[0]) begin
        two_stop                <= wdata_q[`MODE_STOP];
        data_parity_sel         <= wdata_q[`MODE_PSEL_LO +: 2];
        infrared_encoder_enable <= wdata_q[`MODE_INFRARED_ENCODER_ENABLE];
      end
      if (aw_addr_q == `OFS_BAUD) begin
        if (wstrb_q[0]) baud_div[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) baud_div[15:8] <= wdata_q[15:8];
      end
      if (aw_addr_q == `OFS_IRQ_MASK && wstrb_q[0]) begin
        irq_mask <= wdata_q[3:0];
      end
    end
  end

  // Overrun: hardware sets it, software may only clear it
  assign ovr_clear = wr_sta && wstrb_q[0] && !wdata_q[`STA_OVERRUN_ERROR_FLAG]
                     && overrun_error_flag;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_error_flag <= 1'b0;
    end else if (rx_done && rx_accept && rx_count == `FIFO_DEPTH) begin
      overrun_error_flag <= 1'b1;
    end else if (ovr_clear) begin
      overrun_error_flag <= 1'b0;
    end
  end

  // ================================================================
  // Interrupt status: sticky, write one to clear, set wins
  assign rx_level_hit = rx_irq_level_sel[1]
                        ? (rx_irq_level_sel[0] ? (rx_count == `FIFO_DEPTH)
                                               : (rx_count >= `RX_LVL_3Q))
                        : rx_data_available;
  assign irq_event = {rx_push && (rx_new.parity_error_flag || rx_new.framing_error_flag),
                      rx_done && rx_accept && rx_count == `FIFO_DEPTH,
                      tx_enable && tx_count == 3'd0,
                      rx_level_hit};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 4'h0;
    end else begin
      irq_status <= (irq_status
                     & ~((do_write && aw_addr_q == `OFS_IRQ_STAT && wstrb_q[0])
                         ? wdata_q[3:0] : 4'h0))
                    | irq_event;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ================================================================
  // Read side; a read of the receive data pops the head
  assign arready = !rvalid;
  assign do_read = arvalid && arready;
  assign rx_pop  = do_read && (araddr == `OFS_RXDATA);

  assign rx_data_available = (rx_count != 3'd0);
  assign receiver_idle     = (rx_state == RX_IDLE);
  assign tx_buffer_full    = (tx_count == `FIFO_DEPTH);
  assign tx_shifter_empty  = (tx_count == 3'd0) && (tx_state == TX_IDLE);
  assign sta_word = {1'b0, tx_polarity_invert, 3'b000, tx_enable,
                     tx_buffer_full, tx_shifter_empty, rx_irq_level_sel,
                     address_detect_enable, receiver_idle,
                     rx_data_available && rx_head.parity_error_flag,
                     rx_data_available && rx_head.framing_error_flag,
                     overrun_error_flag, rx_data_available};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'b00;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rresp  <= 2'b00;
      unique case (araddr)
        `OFS_STATUS:   rdata <= {16'h0000, sta_word};
        `OFS_MODE:     rdata <= {28'h000_0000, infrared_encoder_enable,
                                 data_parity_sel, two_stop};
        `OFS_BAUD:     rdata <= {16'h0000, baud_div};
        `OFS_TXDATA:   rdata <= 32'h0000_0000;
        `OFS_RXDATA:   rdata <= {23'h00_0000, rx_head.data};
        `OFS_IRQ_STAT: rdata <= {28'h000_0000, irq_status};
        `OFS_IRQ_MASK: rdata <= {28'h000_0000, irq_mask};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= 2'b10;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ================================================================
  // Oversample divider
  always_ff @(posedge aclk) begin
    if (!aresetn || baud_cnt >= baud_div) begin
      baud_cnt <= 16'h0000;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
    end
  end
  assign tick16    = aresetn && (baud_cnt >= baud_div);
  assign nine_bit  = (data_parity_sel == 2'b11);
  assign parity_on = (data_parity_sel == 2'b01) || (data_parity_sel == 2'b10);

  // ================================================================
  // Transmitter; writes into a full buffer are dropped unless a load pops that cycle
  assign tx_push = do_write && (aw_addr_q == `OFS_TXDATA) && tx_enable;
  assign tx_load = tx_enable && (tx_state == TX_IDLE) && (tx_count != 3'd0);

  uart_fifo #(.DW(9)) u_tx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (!tx_enable),
    .push      (tx_push),
    .push_data (wdata_q[8:0]),
    .pop       (tx_load),
    .head      (tx_head),
    .count     (tx_count)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_enable) begin
      tx_state <= TX_IDLE;
      tx_sub   <= 4'd0;
      tx_bit   <= 4'd0;
      tx_shift <= 9'h000;
      tx_par   <= 1'b0;
    end else if (tx_load) begin
      tx_state <= TX_START;
      tx_sub   <= 4'd0;
      tx_bit   <= 4'd0;
      tx_shift <= nine_bit ? tx_head : {1'b0, tx_head[7:0]};
      tx_par   <= (^tx_head[7:0]) ^ data_parity_sel[1];
    end else if (tx_state != TX_IDLE && tick16) begin
      tx_sub <= tx_sub + 4'd1;
      if (tx_sub == `SUB_LAST) begin
        unique case (tx_state)
          TX_START: tx_state <= TX_DATA;
          TX_DATA: begin
            tx_shift <= {1'b0, tx_shift[8:1]};
            tx_bit   <= tx_bit + 4'd1;
            if (tx_bit == (nine_bit ? 4'd8 : 4'd7)) begin
              tx_bit   <= 4'd0;
              tx_state <= parity_on ? TX_PARITY : TX_STOP;
            end
          end
          TX_PARITY: tx_state <= TX_STOP;
          TX_STOP: begin
            tx_bit <= tx_bit + 4'd1;
            if (!two_stop || tx_bit == 4'd1) tx_state <= TX_IDLE;
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // Line level, then the infrared pulse shaper in front of the pin
  always_comb begin
    unique case (tx_state)
      TX_START:  tx_line = 1'b0;
      TX_DATA:   tx_line = tx_shift[0];
      TX_PARITY: tx_line = tx_par;
      default:   tx_line = 1'b1;
    endcase
    if (infrared_encoder_enable) begin
      // Short pulse for each zero bit; only here may polarity flip
      next_tx_pin = (!tx_line && tx_sub < `IR_PULSE) ^ tx_polarity_invert;
    end else begin
      next_tx_pin = tx_line;
    end
  end

  // Registered pin; released to port control while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_tx_pin <= 1'b1;
      serial_tx_oe  <= 1'b0;
    end else begin
      serial_tx_pin <= next_tx_pin;
      serial_tx_oe  <= tx_enable;
    end
  end

  // ================================================================
  // Receiver; samples at mid-bit, resyncs at the stop bit
  assign rx_done   = (rx_state == RX_STOP) && tick16 && (rx_sub == `SUB_MID);
  assign rx_new    = '{parity_error_flag: rx_parity_error_flag_q, framing_error_flag: !serial_rx_in,
                       data: nine_bit ? rx_shift : {1'b0, rx_shift[8:1]}};
  assign rx_accept = !(address_detect_enable && nine_bit) || rx_shift[8];
  assign rx_push   = rx_done && rx_accept && !ovr_clear;

  uart_fifo #(.DW(11)) u_rx_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (ovr_clear),
    .push      (rx_push),
    .push_data (rx_new),
    .pop       (rx_pop),
    .head      (rx_head),
    .count     (rx_count)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || ovr_clear) begin
      rx_state  <= RX_IDLE;
      rx_sub    <= 4'd0;
      rx_bit    <= 4'd0;
      rx_shift  <= 9'h000;
      rx_parity_error_flag_q <= 1'b0;
    end else if (rx_state == RX_IDLE) begin
      if (!serial_rx_in) begin
        rx_state  <= RX_START;
        rx_sub    <= 4'd0;
        rx_bit    <= 4'd0;
        rx_parity_error_flag_q <= 1'b0;
      end
    end else if (tick16) begin
      rx_sub <= rx_sub + 4'd1;
      if (rx_sub == `SUB_MID) begin
        unique case (rx_state)
          RX_START: if (serial_rx_in) rx_state <= RX_IDLE; // False start
          RX_DATA:  rx_shift <= {serial_rx_in, rx_shift[8:1]};
          RX_PARITY: rx_parity_error_flag_q <= serial_rx_in
                                  != ((^rx_shift[8:1]) ^ data_parity_sel[1]);
          RX_STOP:  rx_state <= RX_IDLE;
          default:  rx_state <= RX_IDLE;
        endcase
      end else if (rx_sub == `SUB_LAST) begin
        if (rx_state == RX_START) rx_state <= RX_DATA;
        if (rx_state == RX_PARITY) rx_state <= RX_STOP;
        if (rx_state == RX_DATA) begin
          rx_bit <= rx_bit + 4'd1;
          if (rx_bit == (nine_bit ? 4'd8 : 4'd7)) begin
            rx_state <= parity_on ? RX_PARITY : RX_STOP;
          end
        end
      end
    end
  end

  // ================================================================
  // Checks on the flags and their causes
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_txbf_holds: assert property (tx_push && tx_buffer_full && !tx_load
    |=> tx_count == $past(tx_count)) else $error("push into full tx buffer");
  a_rx_lvl_full: assert property (rx_irq_level_sel == 2'b11 && rx_count < 3'd4
    |-> !rx_level_hit) else $error("rx level early");
  a_addr_drop: assert property (rx_done && address_detect_enable && nine_bit
    && !rx_shift[8] && !rx_pop |=> $stable(rx_count)) else $error("address kept");
  a_idle_leaves: assert property (receiver_idle && !serial_rx_in && !ovr_clear
    |=> !receiver_idle) else $error("receiver stayed idle");
  a_parity_error_flag_head: assert property (rx_push && rx_count == 3'd0 && rx_new.parity_error_flag
    && !rx_pop |=> sta_word[`STA_PARITY_ERROR_FLAG]) else $error("parity flag missing");
  a_framing_error_flag_head: assert property (rx_push && rx_count == 3'd0 && rx_new.framing_error_flag
    && !rx_pop |=> sta_word[`STA_FRAMING_ERROR_FLAG]) else $error("framing flag missing");
  a_ovr_sets: assert property (rx_done && rx_accept && rx_count == 3'd4
    |=> overrun_error_flag ##1 overrun_error_flag) else $error("overrun lost");
  a_ovr_flush: assert property (ovr_clear
    |=> rx_count == 3'd0 && receiver_idle) else $error("clear did not flush");
  a_rxda_drop: assert property (rx_pop && rx_count == 3'd1 && !rx_push
    |=> !rx_data_available) else $error("data flag stuck");
  a_plain_idle: assert property (!infrared_encoder_enable && tx_state == TX_IDLE
    |=> serial_tx_pin) else $error("idle line not high");
  a_parity_state: assert property (tx_state == TX_PARITY
    |-> parity_on) else $error("parity bit without parity");
  a_txen_abort: assert property (!tx_enable |=> !serial_tx_oe
    && tx_count == 3'd0 && tx_state == TX_IDLE) else $error("no abort");
  a_tx_shifter_empty_push: assert property (tx_push && !tx_buffer_full
    |=> !tx_shifter_empty) else $error("shifter empty after push");

  c_overrun:  cover property (rx_done && rx_count == 3'd4);
  c_ovr_clr:  cover property (ovr_clear);
  c_ir_frame: cover property (infrared_encoder_enable && tx_state == TX_STOP);
  c_nine_bit: cover property (rx_push && nine_bit && rx_new.data[8]);

endmodule

`default_nettype wire

/* sim/serial_far_end.sv */
// Far-end serial transmitter that drives the block's receive line.
// Assumes BAUD at zero: one bit lasts 16 clocks of aclk.
`default_nettype none

module serial_far_end (
  input  wire logic        aclk,
  input  wire logic        go,    // Start one frame
  input  wire logic [11:0] bits,  // Frame, first bit at 0
  input  wire logic [3:0]  len,   // Bits in the frame
  output logic             line,  // Receive line of the block
  output logic             busy   // Frame under way
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [11:0] sh = 12'hfff;  // Bits still to send
  logic [3:0]  cnt = 4'h0;    // Clock within the bit
  logic [3:0]  left = 4'h0;   // Bits still to send
  initial busy = 1'b0;

  // ================================================================
  // Shifter: a new bit every 16 clocks
  always @(posedge aclk) begin
    if (go && !busy) begin
      sh <= bits;
      left <= len;
      cnt <= 4'h0;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'hf) begin
        sh <= {1'b1, sh[11:1]};
        left <= left - 4'h1;
        busy <= (left != 4'h1);
      end
    end
  end

  // Idle high, so the receiver sees no false start between frames
  assign line = busy ? sh[0] : 1'b1;
endmodule

`default_nettype wire

/* sim/test_uart_status_control.sv */
// Self-checking bench of the serial status/control block.
// Assumes the far-end model and BAUD left at its reset value.
`include "uart_status_control_regs.svh"
`default_nettype none

module test_uart_status_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0]  wstrb = 4'hf;  // Whole words only
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        rx_line, tx_pin, tx_oe, irq, go = 1'b0, busy;
  logic [11:0] bits = 12'hfff;
  logic [3:0]  len = 4'h0;
  logic [31:0] s;
  logic [1:0]  r;
  int          bad_count = 0, n_tests = 0, cyc = 0;

  uart_status_control dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_rx_in(rx_line), .serial_tx_pin(tx_pin), .serial_tx_oe(tx_oe), .irq(irq));
  serial_far_end far (.aclk(aclk), .go(go), .bits(bits), .len(len),
    .line(rx_line), .busy(busy));

  // ================================================================
  // Clock and hang guard
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  // ================================================================
  // Shared tasks
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    s = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // One frame; p is parity or the ninth bit; idle flag looked at mid-frame
  task automatic send(input logic [7:0] d, input logic hp, input logic p, input logic stp);
    logic [11:0] f;
    int n;
    f = {1'b1, stp, p, d, 1'b0};
    n = hp ? 11 : 10;
    if (!hp) f[9] = stp;
    @(posedge aclk);
    bits <= f;
    len <= 4'(n);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (40) @(posedge aclk);
    rd(`OFS_STATUS);
    chk(32'(s[`STA_RECEIVER_IDLE]), 32'h0000_0000);
    while (busy) @(posedge aclk);
    repeat (4) @(posedge aclk);
    #1;
  endtask

  // ================================================================
  // Scenarios
  task automatic t_reset_map();
    rd(`OFS_STATUS);
    chk(s, 32'h0000_0110);
    rd(8'h1c);
    chk({s[31:2], r}, 32'h0000_0002);
    wr(8'h1c, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
  endtask

  // Fill the transmitter, then disable it in mid-frame
  task automatic t_tx();
    wr(`OFS_STATUS, 32'h0000_0400);
    chk(32'(tx_oe), 32'h0000_0001);
    for (int i = 0; i < 5; i++) wr(`OFS_TXDATA, 32'h0000_0041 + i);
    rd(`OFS_STATUS);
    chk(32'(s[9:8]), 32'h0000_0002);
    wr(`OFS_STATUS, 32'h0000_0000);
    @(posedge aclk);
    #1;
    chk(32'(tx_oe), 32'h0000_0000);
    rd(`OFS_STATUS);
    chk(32'(s[9:8]), 32'h0000_0001);
    wr(`OFS_STATUS, 32'h0000_4400);
    chk(32'(tx_pin), 32'h0000_0001);
    wr(`OFS_MODE, 32'h0000_0008);
    chk(32'(tx_pin), 32'h0000_0001);
    wr(`OFS_STATUS, 32'h0000_0400);
    chk(32'(tx_pin), 32'h0000_0000);
    wr(`OFS_STATUS, 32'h0000_0000);
  endtask

  // Bad parity, then a low stop bit, each seen at the head
  task automatic t_errors();
    wr(`OFS_MODE, 32'h0000_0002);
    send(8'h01, 1'b1, 1'b0, 1'b1);
    rd(`OFS_STATUS);
    chk(32'(s[3:0]), 32'h0000_0009);
    rd(`OFS_RXDATA);
    chk(s, 32'h0000_0001);
    wr(`OFS_MODE, 32'h0000_0004);
    send(8'h03, 1'b1, 1'b1, 1'b0);
    repeat (250) @(posedge aclk);
    rd(`OFS_STATUS);
    chk(32'(s[3:2]), 32'h0000_0001);
    rd(`OFS_RXDATA);
    rd(`OFS_RXDATA);
    rd(`OFS_STATUS);
    chk(32'(s[0]), 32'h0000_0000);
  endtask

  // Interrupt at four, overrun on the fifth, clearing flushes
  task automatic t_overrun();
    wr(`OFS_MODE, 32'h0000_0000);
    wr(`OFS_IRQ_STAT, 32'h0000_000f);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    wr(`OFS_STATUS, 32'h0000_00c0);
    for (int i = 0; i < 5; i++) begin
      send(8'h10 + 8'(i), 1'b0, 1'b0, 1'b1);
      if (i < 4) chk(32'(irq), 32'(i == 3));
      if (i == 2) begin
        wr(`OFS_STATUS, 32'h0000_0080);
        chk(32'(irq), 32'h0000_0001);
        wr(`OFS_STATUS, 32'h0000_00c0);
        wr(`OFS_IRQ_STAT, 32'h0000_0001);
      end
    end
    rd(`OFS_STATUS);
    chk(32'(s[1:0]), 32'h0000_0003);
    wr(`OFS_STATUS, 32'h0000_00c0);
    rd(`OFS_STATUS);
    chk(32'(s[1:0]), 32'h0000_0000);
    wr(`OFS_IRQ_STAT, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // Nine-bit frames; only address characters pass the detector
  task automatic t_address();
    wr(`OFS_MODE, 32'h0000_0006);
    wr(`OFS_STATUS, 32'h0000_0020);
    send(8'h55, 1'b1, 1'b0, 1'b1);
    rd(`OFS_STATUS);
    chk(32'(s[0]), 32'h0000_0000);
    send(8'ha5, 1'b1, 1'b1, 1'b1);
    rd(`OFS_RXDATA);
    chk(s, 32'h0000_01a5);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_tx();
    t_errors();
    t_overrun();
    t_address();
    give_verdict();
  end
endmodule

`default_nettype wire
